// [rtl/lls_regs.vh]
// register indices, field positions, reset values for the lane status block
// assumes byte address = 4 * index on a 32-bit AXI4-Lite bus
`ifndef LLS_REGS_VH
`define LLS_REGS_VH

// register indices, byte address is four times the index
`define LLS_IDX_CTRL_ERR 12'h46f
`define LLS_IDX_CG_LOCK 12'h470
`define LLS_IDX_FR_LOCK 12'h471
`define LLS_IDX_IRQ_STATUS 12'h480
`define LLS_IDX_IRQ_CLEAR 12'h481
`define LLS_IDX_IRQ_ENABLE 12'h482

// field positions
`define LLS_FR_LOCK_BIT 7
`define LLS_IRQ_CG_LSB 0
`define LLS_IRQ_ERR_LSB 8
`define LLS_IRQ_FR_BIT 16
`define LLS_IRQ_WIDTH 17

// reset values
`define LLS_FLAGS_RESET 8'h00
`define LLS_IRQ_RESET 17'h00000

// axi responses
`define LLS_RESP_OKAY 2'b00
`define LLS_RESP_SLVERR 2'b10

`endif

// [rtl/lls_sync3.v]
// three-stage synchroniser with agreement filter for lock inputs
// assumes inputs may change at any time relative to clock_in
`timescale 1ns/10ps
module lls_sync3 #(
    parameter WIDTH = 9
) (
    input wire clock_in,
    input wire rst_in,
    input wire ce_in,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] stage1;
    reg [WIDTH-1:0] stage2;
    reg [WIDTH-1:0] stage3;
    integer i;

    always @(posedge clock_in) begin
        if (rst_in) begin
            stage1 <= {WIDTH{1'b0}};
            stage2 <= {WIDTH{1'b0}};
            stage3 <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else if (ce_in) begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
            // a bit only moves once the two late stages agree
            for (i = 0; i < WIDTH; i = i + 1) begin
                if (stage2[i] == stage3[i]) begin
                    sync_out[i] <= stage3[i];
                end
            end
        end
    end
endmodule

// [rtl/lls_lane_status.v]
// lane status flags: control-char error, code group lock, frame lock
// assumes error counts and threshold come from logic on clock_in,
// lock levels come from the lane receivers in another domain
//
// Behaviour
// - one error flag per lane, bit n
// - flag reads 0 below error threshold
// - flag reads 1 at or above threshold
// - code group lock per lane at 0x470
// - lane 7 frame lock at bit 7
`timescale 1ns/10ps
`include "lls_regs.vh"
module lls_lane_status (
    input wire clock_in,
    input wire rst_in,
    input wire ce_in,
    input wire [63:0] lane_error_count_in,
    input wire [7:0] error_count_threshold_in,
    input wire [7:0] lane_code_group_lock_in,
    input wire lane7_frame_lock_in,
    input wire [15:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [15:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg irq_out
);
    reg [7:0] lane_control_char_error_status;
    reg [7:0] lane_code_group_lock_status;
    reg [7:0] lane_frame_lock_status;
    reg [16:0] irq_status;
    reg [16:0] irq_enable;
    reg [15:0] aw_addr;
    reg aw_held;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    reg w_held;
    reg [7:0] next_err;
    reg [16:0] next_irq_status;
    reg [16:0] irq_events;
    reg [16:0] irq_clear;
    reg [31:0] read_mux;
    reg read_ok;
    wire [8:0] lock_sync;
    wire do_write;
    integer n;

    function lls_hit;
        input [15:0] addr;
        input [11:0] idx;
        begin
            lls_hit = (addr[15:14] == 2'b00) && (addr[13:2] == idx);
        end
    endfunction

    // lock levels cross from the lane clock; counts are already local
    lls_sync3 #(
        .WIDTH(9)
    ) u_lock_sync (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .async_in({lane7_frame_lock_in, lane_code_group_lock_in}),
        .sync_out(lock_sync)
    );

    always @* begin
        for (n = 0; n < 8; n = n + 1) begin
            // count >= threshold gives 1, below gives 0
            next_err[n] = (lane_error_count_in[n*8 +: 8] >=
                           error_count_threshold_in);
        end
    end

    assign do_write = aw_held && w_held && !s_axi_bvalid;

    always @* begin
        irq_events = {`LLS_IRQ_WIDTH{1'b0}};
        // lock losses and error flag assertions are the interrupt events
        irq_events[`LLS_IRQ_CG_LSB +: 8] = lane_code_group_lock_status &
                                          ~lock_sync[7:0];
        irq_events[`LLS_IRQ_ERR_LSB +: 8] = next_err &
                                           ~lane_control_char_error_status;
        irq_events[`LLS_IRQ_FR_BIT] =
            lane_frame_lock_status[`LLS_FR_LOCK_BIT] & ~lock_sync[8];
        irq_clear = {`LLS_IRQ_WIDTH{1'b0}};
        if (do_write && lls_hit(aw_addr, `LLS_IDX_IRQ_CLEAR)) begin
            irq_clear[7:0] = w_strb[0] ? w_data[7:0] : 8'h00;
            irq_clear[15:8] = w_strb[1] ? w_data[15:8] : 8'h00;
            irq_clear[16] = w_strb[2] & w_data[16];
        end
        // an event in the clearing cycle survives the clear
        next_irq_status = (irq_status & ~irq_clear) | irq_events;
    end

    always @* begin
        read_mux = 32'h00000000;
        read_ok = 1'b1;
        if (lls_hit(s_axi_araddr, `LLS_IDX_CTRL_ERR)) begin
            read_mux[7:0] = lane_control_char_error_status;
        end else if (lls_hit(s_axi_araddr, `LLS_IDX_CG_LOCK)) begin
            read_mux[7:0] = lane_code_group_lock_status;
        end else if (lls_hit(s_axi_araddr, `LLS_IDX_FR_LOCK)) begin
            // value is meaningless to software when alignment is skipped
            read_mux[7:0] = lane_frame_lock_status;
        end else if (lls_hit(s_axi_araddr, `LLS_IDX_IRQ_STATUS)) begin
            read_mux[16:0] = irq_status;
        end else if (lls_hit(s_axi_araddr, `LLS_IDX_IRQ_CLEAR)) begin
            read_mux = 32'h00000000;
        end else if (lls_hit(s_axi_araddr, `LLS_IDX_IRQ_ENABLE)) begin
            read_mux[16:0] = irq_enable;
        end else begin
            read_ok = 1'b0;
        end
    end

    // status flags track the lanes every enabled cycle
    always @(posedge clock_in) begin
        if (rst_in) begin
            lane_control_char_error_status <= `LLS_FLAGS_RESET;
            lane_code_group_lock_status <= `LLS_FLAGS_RESET;
            lane_frame_lock_status <= `LLS_FLAGS_RESET;
            irq_status <= `LLS_IRQ_RESET;
            irq_out <= 1'b0;
        end else if (ce_in) begin
            lane_control_char_error_status <= next_err;
            lane_code_group_lock_status <= lock_sync[7:0];
            lane_frame_lock_status <= {lock_sync[8], 7'h00};
            irq_status <= next_irq_status;
            irq_out <= |(irq_status & irq_enable);
        end
    end

    // axi4-lite write side; flag registers ignore writes entirely
    always @(posedge clock_in) begin
        if (rst_in) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `LLS_RESP_OKAY;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 16'h0000;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            irq_enable <= `LLS_IRQ_RESET;
        end else if (ce_in) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr <= s_axi_awaddr;
                aw_held <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                w_held <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `LLS_RESP_OKAY;
                if (lls_hit(aw_addr, `LLS_IDX_IRQ_ENABLE)) begin
                    if (w_strb[0]) begin
                        irq_enable[7:0] <= w_data[7:0];
                    end
                    if (w_strb[1]) begin
                        irq_enable[15:8] <= w_data[15:8];
                    end
                    if (w_strb[2]) begin
                        irq_enable[16] <= w_data[16];
                    end
                end else if (!(lls_hit(aw_addr, `LLS_IDX_CTRL_ERR) ||
                               lls_hit(aw_addr, `LLS_IDX_CG_LOCK) ||
                               lls_hit(aw_addr, `LLS_IDX_FR_LOCK) ||
                               lls_hit(aw_addr, `LLS_IDX_IRQ_STATUS) ||
                               lls_hit(aw_addr, `LLS_IDX_IRQ_CLEAR))) begin
                    s_axi_bresp <= `LLS_RESP_SLVERR;
                end
            end
        end
    end

    // axi4-lite read side, one read outstanding
    always @(posedge clock_in) begin
        if (rst_in) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `LLS_RESP_OKAY;
        end else if (ce_in) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= read_mux;
                s_axi_rresp <= read_ok ? `LLS_RESP_OKAY : `LLS_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule

// [testbench/lls_lane_status_chk.sv]
// checker for the lane status register port and interrupt
// assumes it is bound to each lls_lane_status instance
`timescale 1ns/10ps
module lls_lane_status_chk (
    input wire clock_in,
    input wire rst_in,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire irq_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    reset_clear_a:
        assert property ($fell(rst_in) |-> !s_axi_bvalid && !s_axi_rvalid
            && !irq_out) else $error("busy after reset");
    read_answer_a:
        assert property (s_axi_arvalid && s_axi_arready
            |=> s_axi_rvalid && !s_axi_arready) else $error("late read");
    write_answer_a:
        assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
            && s_axi_wready |=> !s_axi_awready ##1 s_axi_bvalid)
            else $error("late write response");
    bresp_hold_a:
        assert property (s_axi_bvalid && !s_axi_bready
            |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b drop");
    rdata_hold_a:
        assert property (s_axi_rvalid && !s_axi_rready
            |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("r drop");
    bvalid_end_a:
        assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
            else $error("bvalid stuck");
    rvalid_end_a:
        assert property (s_axi_rvalid && s_axi_rready
            |=> !s_axi_rvalid ##1 s_axi_arready) else $error("rvalid stuck");
    slverr_zero_a:
        assert property (s_axi_rvalid && s_axi_rresp == 2'b10
            |-> s_axi_rdata == 32'h0) else $error("error read not zero");
endmodule
bind lls_lane_status lls_lane_status_chk lls_lane_status_chk_inst (.*);

// [testbench/lls_lane_tx.sv]
// far-end lane model: accumulates error counts, drives lock levels
// assumes the bench pulses err_inc_in and sets lock_in
`timescale 1ns/10ps
module lls_lane_tx (
    input wire clock_in,
    input wire rst_in,
    input wire [7:0] err_inc_in,
    input wire [8:0] lock_in,
    output reg [63:0] lane_error_count_out,
    output reg [7:0] lane_code_group_lock_out,
    output reg lane7_frame_lock_out
);
    integer n;
    always @(posedge clock_in) begin
        for (n = 0; n < 8; n = n + 1) begin
            if (rst_in)
                lane_error_count_out[8*n +: 8] <= 8'h00;
            else if (err_inc_in[n] && lane_error_count_out[8*n +: 8] != 8'hff)
                lane_error_count_out[8*n +: 8] <=
                    lane_error_count_out[8*n +: 8] + 8'h01;
        end
        {lane7_frame_lock_out, lane_code_group_lock_out} <= lock_in;
    end
endmodule

// [testbench/lls_lane_status_tb_top.sv]
// bench for lls_lane_status: flag table, read-only, irq, reset
// assumes lls_lane_tx as far end and the checker bound to the design
`timescale 1ns/10ps
module lls_lane_status_tb_top;
    reg clock_in = 0, rst_in = 1, ce_in = 1;
    // threshold above zero so the idle counts of zero read as clear
    reg [7:0] err_inc = 0, error_count_threshold_in = 8'h01;
    reg [8:0] lock = 0;
    wire [63:0] lane_error_count_in;
    wire [7:0] lane_code_group_lock_in;
    wire lane7_frame_lock_in, s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire s_axi_arready, s_axi_rvalid, irq_out;
    reg [15:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    reg [31:0] s_axi_wdata = 0, got;
    reg [3:0] s_axi_wstrb = 4'hf;
    reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    reg s_axi_arvalid = 0, s_axi_rready = 0;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    reg [1:0] resp;
    reg [40:0] rows [0:4];
    integer fail_count = 0, checks_done = 0, i;
    lls_lane_tx lls_lane_tx_inst (.clock_in(clock_in), .rst_in(rst_in),
        .err_inc_in(err_inc), .lock_in(lock),
        .lane_error_count_out(lane_error_count_in),
        .lane_code_group_lock_out(lane_code_group_lock_in),
        .lane7_frame_lock_out(lane7_frame_lock_in));
    lls_lane_status lls_lane_status_inst (.clock_in(clock_in),
        .rst_in(rst_in), .ce_in(ce_in),
        .lane_error_count_in(lane_error_count_in),
        .error_count_threshold_in(error_count_threshold_in),
        .lane_code_group_lock_in(lane_code_group_lock_in),
        .lane7_frame_lock_in(lane7_frame_lock_in),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .irq_out(irq_out));
    task chk(input string nm, input [31:0] e, input [31:0] g);
        begin
            checks_done = checks_done + 1;
            if (g !== e) begin
                fail_count = fail_count + 1;
                $display("mismatch %s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task wr(input [15:0] a, input [31:0] d);
        begin
            @(posedge clock_in);
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            // ready comes a cycle late so the slave must hold its answer
            do begin
                @(posedge clock_in);
                if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
                if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
                if (s_axi_bvalid === 1'b1 && !s_axi_bready)
                    s_axi_bready <= 1'b1;
            end while (!(s_axi_bvalid === 1'b1 && s_axi_bready));
            s_axi_bready <= 1'b0;
            resp = s_axi_bresp;
        end
    endtask
    task rd(input [15:0] a);
        begin
            @(posedge clock_in);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            do begin
                @(posedge clock_in);
                if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
                if (s_axi_rvalid === 1'b1 && !s_axi_rready)
                    s_axi_rready <= 1'b1;
            end while (!(s_axi_rvalid === 1'b1 && s_axi_rready));
            s_axi_rready <= 1'b0;
            got = s_axi_rdata;
            resp = s_axi_rresp;
        end
    endtask
    task zero_chk;
        for (i = 0; i < 3; i = i + 1) begin
            rd(16'h11bc + 16'(i * 4));
            chk("flags after reset", 32'h0, got);
        end
    endtask
    task irq_chk(input e);
        begin
            // lock path: model, three stages, agreement, status, irq
            repeat (10) @(posedge clock_in);
            chk("irq_out", {31'h0, e}, {31'h0, irq_out});
        end
    endtask
    task conclude;
        begin
            $display("checks %0d mismatches %0d", checks_done, fail_count);
            if (fail_count == 0 && checks_done > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    initial forever #20 clock_in = ~clock_in;
    initial begin
        #2000000;
        fail_count = fail_count + 1;
        conclude;
    end
    initial begin
        // threshold, lock levels, then expected error, lock, frame flags
        rows[0] = {8'h00, 9'h1ff, 8'hff, 8'hff, 8'h80};
        rows[1] = {8'h02, 9'h0a5, 8'hfe, 8'ha5, 8'h00};
        rows[2] = {8'h0e, 9'h15a, 8'h80, 8'h5a, 8'h80};
        rows[3] = {8'h0f, 9'h000, 8'h00, 8'h00, 8'h00};
        rows[4] = {8'h07, 9'h100, 8'hf0, 8'h00, 8'h80};
        repeat (8) @(posedge clock_in);
        rst_in <= 1'b0;
        zero_chk;
        // lane n ends with an error count of 2n
        for (i = 0; i < 14; i = i + 1) begin
            @(posedge clock_in);
            err_inc <= 8'hff << (i / 2 + 1);
        end
        @(posedge clock_in);
        err_inc <= 8'h00;
        for (i = 0; i < 5; i = i + 1) begin
            @(posedge clock_in);
            {error_count_threshold_in, lock} <= rows[i][40:24];
            wr(16'h11bc, 32'hffffffff);
            chk("ro write resp", 32'h0, {30'h0, resp});
            repeat (6) @(posedge clock_in);
            rd(16'h11bc);
            chk("error flags", {24'h0, rows[i][23:16]}, got);
            rd(16'h11c0);
            chk("code group lock", {24'h0, rows[i][15:8]}, got);
            rd(16'h11c4);
            // alignment sequence is never skipped here, so the bit counts
            chk("frame lock", {24'h0, rows[i][7:0]}, got);
        end
        rd(16'h0000);
        chk("unmapped resp", 32'h2, {30'h0, resp});
        wr(16'h0000, 32'h0);
        chk("unmapped write resp", 32'h2, {30'h0, resp});
        wr(16'h1204, 32'h1ffff);
        wr(16'h1208, 32'h1);
        lock <= 9'h001;
        irq_chk(1'b0);
        lock <= 9'h000;
        irq_chk(1'b1);
        rd(16'h1200);
        chk("irq status", 32'h10001, got);
        wr(16'h1208, 32'h0);
        irq_chk(1'b0);
        wr(16'h1208, 32'h1);
        irq_chk(1'b1);
        wr(16'h1204, 32'h1);
        irq_chk(1'b0);
        // a lock pulse while disabled must leave no loss event behind
        ce_in <= 1'b0;
        lock <= 9'h001;
        irq_chk(1'b0);
        lock <= 9'h000;
        irq_chk(1'b0);
        ce_in <= 1'b1;
        irq_chk(1'b0);
        rst_in <= 1'b1;
        repeat (2) @(posedge clock_in);
        rst_in <= 1'b0;
        zero_chk;
        conclude;
    end
endmodule
